// ==== shared/pmsc_pkg.sv ====
package pmsc_pkg;

    // ----------------------------------------
    // Widths and memory geometry
    // ----------------------------------------
    localparam int IO_W = 16;
    localparam int WORD_W = 16;
    localparam int DWORD_W = 32;
    localparam int AUX_WORDS = 8;
    localparam int AUX_AW = 3;
    localparam int DATA_AW = 12;
    localparam int DATA_WORDS = 2560;
    localparam logic [DATA_AW-1:0] PRESET_BASE = 12'h800;
    localparam logic [DATA_AW-1:0] PRESET_LAST = 12'h8FF;
    localparam logic [DATA_AW-1:0] CURRENT_BASE = 12'h900;
    localparam logic [DATA_AW-1:0] CURRENT_LAST = 12'h9FF;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam int ADDR_W = 16;
    localparam logic [1:0] AREA_AUX = 2'h0;
    localparam logic [1:0] AREA_KEEP = 2'h1;
    localparam logic [1:0] AREA_DATA = 2'h2;
    localparam logic [1:0] AREA_CTRL = 2'h3;
    localparam logic [3:0] CTRL_STATUS = 4'h0;
    localparam logic [3:0] CTRL_FORCE_EN = 4'h1;
    localparam logic [3:0] CTRL_FORCE_VAL = 4'h2;
    localparam logic [3:0] CTRL_WD_LIMIT = 4'h3;
    localparam logic [3:0] CTRL_PROG = 4'h4;
    localparam logic [3:0] CTRL_INPUTS = 4'h5;
    localparam logic [3:0] CTRL_CLEAR_DATA = 4'h6;
    localparam logic [3:0] CTRL_DWORD_LO = 4'h7;
    localparam logic [3:0] CTRL_DWORD_HI = 4'h8;
    localparam logic [3:0] CTRL_WD_COUNT = 4'h9;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int WD_LIMIT_MAX_S = 3;
    localparam longint WD_MAX_CYCLES = longint'(WD_LIMIT_MAX_S) * CLK_MHZ * 1000000;
    localparam int WD_W = 30;
    localparam logic [WD_W-1:0] WD_MAX = WD_MAX_CYCLES[WD_W-1:0];
    localparam int WD_UNIT = 4096;
    localparam logic [WORD_W-1:0] WD_LIMIT_RESET = 16'hFFFF;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        SW_RUN = 2'h0,
        SW_REMOTE = 2'h1,
        SW_PROG = 2'h2
    } pmsc_switch_type;

    typedef enum logic [3:0] {
        MODE_RUN = 4'h1,
        MODE_STOP = 4'h2,
        MODE_PAUSE = 4'h4,
        MODE_ERROR = 4'h8
    } pmsc_mode_type;

    typedef enum logic [4:0] {
        STEP_FORCE = 5'h01,
        STEP_IO = 5'h02,
        STEP_WDOG = 5'h04,
        STEP_EXEC = 5'h08,
        STEP_INTAKE = 5'h10
    } pmsc_step_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } pmsc_bus_type;

    typedef struct packed {
        logic valid;
        logic [DATA_AW-1:0] addr;
        logic [WORD_W-1:0] data;
    } pmsc_periph_type;

endpackage : pmsc_pkg

// ==== logic/pmsc_top.sv ====
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module pmsc_top
    import pmsc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Front panel and diagnostics
    input wire logic [1:0] mode_switch,
    input wire logic init_key,
    input wire logic diag_error,
    // Host remote commands
    input wire logic host_run_cmd,
    input wire logic host_pause_cmd,
    // Input and output modules
    input wire logic [IO_W-1:0] ext_inputs,
    output logic [IO_W-1:0] ext_outputs,
    // Peripheral data intake
    input wire pmsc_periph_type periph,
    // Register port
    input wire pmsc_bus_type bus,
    output logic [WORD_W-1:0] rdata,
    // Indicators
    output logic [3:0] mode,
    output logic [4:0] scan_step,
    output logic run_led,
    output logic prog_led,
    output logic error_led,
    output logic alarm_relay,
    output logic wd_fault
);

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic rst_meta_r, rst_sync_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire logic rst_n = rst_sync_r;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic is_ctrl(input logic [ADDR_W-1:0] a, input logic [3:0] r);
        is_ctrl = (a[ADDR_W-1 -: 2] == AREA_CTRL) && (a[3:0] == r);
    endfunction : is_ctrl

    function automatic logic is_area(input logic [ADDR_W-1:0] a, input logic [1:0] ar);
        is_area = (a[ADDR_W-1 -: 2] == ar);
    endfunction : is_area

    // ----------------------------------------
    // State declarations
    // ----------------------------------------
    pmsc_mode_type mode_r, mode_nxt;
    pmsc_step_type step_r, step_nxt;
    logic remote_pause_r;
    logic boot_r;
    logic [WORD_W-1:0] aux_r [AUX_WORDS];
    logic [WORD_W-1:0] keep_r [AUX_WORDS];
    logic [WORD_W-1:0] data_r [DATA_WORDS];
    logic [IO_W-1:0] force_en_r, force_val_r;
    logic [IO_W-1:0] in_image_r, out_image_r, work_out_r;
    logic [WORD_W-1:0] prog_r;
    logic [WORD_W-1:0] wd_limit_r;
    logic [WD_W-1:0] wd_count_r;
    logic [WORD_W-1:0] dword_hi_r;
    logic [WORD_W-1:0] dword_lo_r;
    logic clear_data_r;

    wire pmsc_switch_type sw = pmsc_switch_type'(mode_switch);
    wire logic running = (mode_r == MODE_RUN);
    wire logic prog_enabled = !(running && sw == SW_RUN);
    wire logic [WD_W-1:0] wd_limit_cyc = WD_W'({wd_limit_r, 12'h000}) + WD_W'(WD_UNIT);
    wire logic wd_over = running && (wd_count_r >= wd_limit_cyc || wd_count_r >= WD_MAX);

    // ----------------------------------------
    // Mode control
    // ----------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            MODE_ERROR: begin
                if (init_key && sw == SW_PROG) begin
                    mode_nxt = MODE_STOP;
                end
            end
            default: begin
                if (boot_r) begin
                    unique case (sw)
                        SW_RUN: mode_nxt = MODE_RUN;
                        SW_PROG: mode_nxt = MODE_STOP;
                        default: mode_nxt = remote_pause_r ? MODE_PAUSE : MODE_RUN;
                    endcase
                end else if (sw == SW_RUN) begin
                    mode_nxt = MODE_RUN;
                end else if (sw == SW_PROG) begin
                    mode_nxt = MODE_STOP;
                end else if (host_run_cmd) begin
                    mode_nxt = MODE_RUN;
                end else if (host_pause_cmd) begin
                    mode_nxt = MODE_PAUSE;
                end else if (mode_r == MODE_STOP) begin
                    mode_nxt = MODE_PAUSE;
                end
                if (diag_error || wd_over) begin
                    mode_nxt = MODE_ERROR;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_STOP;
            boot_r <= 1'b1;
        end else begin
            mode_r <= mode_nxt;
            boot_r <= 1'b0;
        end
    end

    // Remote run/pause choice kept in retentive storage
    always_ff @(posedge clock) begin
        if (mode_r != MODE_ERROR && sw == SW_REMOTE && !boot_r) begin
            if (host_run_cmd) begin
                remote_pause_r <= 1'b0;
            end else if (host_pause_cmd) begin
                remote_pause_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Scan sequencer
    // ----------------------------------------
    always_comb begin
        unique case (step_r)
            STEP_FORCE: step_nxt = STEP_IO;
            STEP_IO: step_nxt = STEP_WDOG;
            STEP_WDOG: step_nxt = STEP_EXEC;
            STEP_EXEC: step_nxt = STEP_INTAKE;
            default: step_nxt = STEP_FORCE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            step_r <= STEP_FORCE;
        end else begin
            step_r <= step_nxt;
        end
    end

    // ----------------------------------------
    // I/O images and program execution
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            in_image_r <= '0;
            work_out_r <= '0;
            out_image_r <= '0;
        end else begin
            unique case (step_r)
                STEP_FORCE: begin
                    in_image_r <= (in_image_r & ~force_en_r) | (force_val_r & force_en_r);
                    work_out_r <= (work_out_r & ~force_en_r) | (force_val_r & force_en_r);
                end
                STEP_IO: begin
                    in_image_r <= (ext_inputs & ~force_en_r) | (force_val_r & force_en_r);
                    out_image_r <= running ? work_out_r : '0;
                end
                STEP_EXEC: begin
                    if (running) begin
                        work_out_r <= (in_image_r & prog_r) ^ aux_r[0] ^ keep_r[0];
                    end else begin
                        work_out_r <= '0;
                    end
                end
                default: begin
                end
            endcase
            if (!running) begin
                out_image_r <= '0;
            end
        end
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wd_count_r <= '0;
            wd_fault <= 1'b0;
        end else begin
            if (step_r == STEP_WDOG || !running) begin
                wd_count_r <= '0;
            end else if (wd_count_r != WD_MAX) begin
                wd_count_r <= wd_count_r + WD_W'(1);
            end
            wd_fault <= (wd_fault && mode_r == MODE_ERROR) || wd_over;
        end
    end

    // ----------------------------------------
    // Software registers and memory areas
    // ----------------------------------------
    wire logic [DATA_AW-1:0] dw_addr = bus.addr[DATA_AW-1:0];
    wire logic wr_aux = bus.wr && is_area(bus.addr, AREA_AUX);
    wire logic wr_keep = bus.wr && is_area(bus.addr, AREA_KEEP);
    wire logic wr_data = bus.wr && is_area(bus.addr, AREA_DATA) && dw_addr < DATA_AW'(DATA_WORDS);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            force_en_r <= '0;
            force_val_r <= '0;
            prog_r <= '0;
            wd_limit_r <= WD_LIMIT_RESET;
            clear_data_r <= 1'b0;
        end else begin
            clear_data_r <= 1'b0;
            if (bus.wr && is_ctrl(bus.addr, CTRL_FORCE_EN)) force_en_r <= bus.wdata;
            if (bus.wr && is_ctrl(bus.addr, CTRL_FORCE_VAL)) force_val_r <= bus.wdata;
            if (bus.wr && is_ctrl(bus.addr, CTRL_WD_LIMIT)) wd_limit_r <= bus.wdata;
            if (bus.wr && is_ctrl(bus.addr, CTRL_PROG) && prog_enabled) begin
                prog_r <= bus.wdata;
            end
            if (bus.wr && is_ctrl(bus.addr, CTRL_PROG) && prog_enabled) begin
                clear_data_r <= 1'b1;
            end
            if (bus.wr && is_ctrl(bus.addr, CTRL_CLEAR_DATA)) clear_data_r <= 1'b1;
        end
    end

    // Nonretentive area, cleared on reset and whenever in stop or error mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < AUX_WORDS; i++) aux_r[i] <= '0;
        end else if (mode_r == MODE_STOP || mode_r == MODE_ERROR) begin
            for (int i = 0; i < AUX_WORDS; i++) aux_r[i] <= '0;
        end else if (wr_aux) begin
            aux_r[bus.addr[AUX_AW-1:0]] <= bus.wdata;
        end
    end

    // Retentive area: no reset
    always_ff @(posedge clock) begin
        if (wr_keep) begin
            keep_r[bus.addr[AUX_AW-1:0]] <= bus.wdata;
        end
    end

    // Data words, presets and current values: no reset, word writes, word or double-word reads
    always_ff @(posedge clock) begin
        if (clear_data_r) begin
            for (int i = 0; i < int'(PRESET_BASE); i++) data_r[i] <= '0;
        end else if (wr_data) begin
            data_r[dw_addr] <= bus.wdata;
        end else if (periph.valid && step_r == STEP_INTAKE) begin
            data_r[periph.addr] <= periph.data;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
            dword_hi_r <= '0;
            dword_lo_r <= '0;
        end else begin
            rdata <= '0;
            if (bus.rd) begin
                if (is_area(bus.addr, AREA_AUX)) rdata <= aux_r[bus.addr[AUX_AW-1:0]];
                else if (is_area(bus.addr, AREA_KEEP)) rdata <= keep_r[bus.addr[AUX_AW-1:0]];
                else if (is_area(bus.addr, AREA_DATA)) begin
                    if (dw_addr < DATA_AW'(DATA_WORDS)) begin
                        rdata <= data_r[dw_addr];
                        dword_lo_r <= data_r[dw_addr];
                        dword_hi_r <= (dw_addr + 1'b1 < DATA_AW'(DATA_WORDS))
                            ? data_r[dw_addr + 1'b1] : '0;
                    end
                end else if (is_ctrl(bus.addr, CTRL_STATUS)) begin
                    rdata <= {7'h00, prog_enabled, wd_fault, remote_pause_r, step_r[0], mode_r, 1'b0};
                end else if (is_ctrl(bus.addr, CTRL_FORCE_EN)) rdata <= force_en_r;
                else if (is_ctrl(bus.addr, CTRL_FORCE_VAL)) rdata <= force_val_r;
                else if (is_ctrl(bus.addr, CTRL_WD_LIMIT)) rdata <= wd_limit_r;
                else if (is_ctrl(bus.addr, CTRL_PROG)) rdata <= prog_r;
                else if (is_ctrl(bus.addr, CTRL_INPUTS)) rdata <= in_image_r;
                else if (is_ctrl(bus.addr, CTRL_DWORD_LO)) rdata <= dword_lo_r;
                else if (is_ctrl(bus.addr, CTRL_DWORD_HI)) rdata <= dword_hi_r;
                else if (is_ctrl(bus.addr, CTRL_WD_COUNT)) rdata <= wd_count_r[WD_W-1 -: WORD_W];
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_outputs <= '0;
            mode <= MODE_STOP;
            scan_step <= STEP_FORCE;
            run_led <= 1'b0;
            prog_led <= 1'b0;
            error_led <= 1'b0;
            alarm_relay <= 1'b0;
        end else begin
            ext_outputs <= running ? out_image_r : '0;
            mode <= mode_r;
            scan_step <= step_r;
            run_led <= running;
            prog_led <= prog_enabled;
            error_led <= (mode_r == MODE_ERROR);
            alarm_relay <= (mode_r == MODE_ERROR);
        end
    end

endmodule : pmsc_top

`default_nettype wire

// ==== dv/pmsc_checker.sv ====
`timescale 1ns/10ps
`default_nettype none

// ------
// Mode and scan checks
// ------
module pmsc_checker
    import pmsc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Panel and diagnostics
    input wire logic [1:0] mode_switch,
    input wire logic init_key,
    input wire logic diag_error,
    // Results
    input wire logic [IO_W-1:0] ext_outputs,
    input wire logic [3:0] mode,
    input wire logic [4:0] scan_step,
    input wire logic alarm_relay
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    AST_ONE_MODE: assert property ($onehot(mode))
        else $error("mode is not one-hot");
    AST_OUT_OFF: assert property ((mode != MODE_RUN)[*3] |-> ext_outputs == '0)
        else $error("outputs on outside run");
    AST_STEP_ORDER: assert property (scan_step == STEP_IO |=> scan_step == STEP_WDOG
        ##1 scan_step == STEP_EXEC ##1 scan_step == STEP_INTAKE
        ##1 scan_step == STEP_FORCE ##1 scan_step == STEP_IO)
        else $error("scan steps out of order");
    AST_ERR_ENTER: assert property (diag_error |-> ##[1:4] mode == MODE_ERROR)
        else $error("diagnostic error not entered");
    AST_ALARM: assert property ($stable(mode)[*3] |-> alarm_relay == (mode == MODE_ERROR))
        else $error("alarm relay disagrees with mode");
    AST_ERR_HOLD: assert property ((mode == MODE_ERROR
        && !(init_key && mode_switch == SW_PROG))[*3] |=> mode == MODE_ERROR)
        else $error("error mode left without cause");
    AST_INIT_CLEAR: assert property (mode == MODE_ERROR && init_key
        && mode_switch == SW_PROG && !diag_error |-> ##[1:3] mode == MODE_STOP)
        else $error("initialize key did not clear error");
    AST_PROG_NO_RUN: assert property ((mode_switch == SW_PROG)[*4] |-> mode != MODE_RUN)
        else $error("run at program switch");
endmodule : pmsc_checker

bind pmsc_top pmsc_checker i_pmsc_checker (.clock(clock), .reset_n(reset_n),
    .mode_switch(mode_switch), .init_key(init_key), .diag_error(diag_error),
    .ext_outputs(ext_outputs), .mode(mode), .scan_step(scan_step), .alarm_relay(alarm_relay));

`default_nettype wire

// ==== dv/pmsc_partner.sv ====
`timescale 1ns/10ps
`default_nettype none

// ------
// Host software and input modules
// ------
module pmsc_partner
    import pmsc_pkg::*;
(
    // Clock
    input wire logic clock,
    // Requests from the bench
    input wire logic load,
    input wire logic [IO_W-1:0] load_value,
    input wire logic run_req,
    input wire logic pause_req,
    // Toward the controller
    output logic [IO_W-1:0] ext_inputs,
    output logic host_run_cmd,
    output logic host_pause_cmd
);
    int hold_cnt = 0;

    initial begin
        ext_inputs = '0;
        host_run_cmd = 1'b0;
        host_pause_cmd = 1'b0;
    end
    // New level only after a hold longer than one scan
    always @(posedge clock) begin
        if (hold_cnt != 0) begin
            hold_cnt <= hold_cnt - 1;
        end else if (load) begin
            ext_inputs <= load_value;
            hold_cnt <= 8;
        end
    end
    // One-cycle remote commands
    always @(posedge clock) begin
        host_run_cmd <= run_req;
        host_pause_cmd <= pause_req;
    end
endmodule : pmsc_partner

`default_nettype wire

// ==== dv/pmsc_top_bench.sv ====
`timescale 1ns/10ps
`default_nettype none

// ------
// Bench
// ------
module pmsc_top_bench
    import pmsc_pkg::*;
;
    logic clock = 0;
    logic reset_n = 0;
    logic [1:0] mode_switch = SW_PROG;
    logic init_key = 0;
    logic diag_error = 0;
    logic load = 0;
    logic run_req = 0;
    logic pause_req = 0;
    logic [IO_W-1:0] load_value = '0;
    logic [IO_W-1:0] ext_inputs;
    logic [IO_W-1:0] ext_outputs;
    logic host_run_cmd;
    logic host_pause_cmd;
    pmsc_periph_type periph = '0;
    pmsc_bus_type bus = '0;
    logic [WORD_W-1:0] rdata;
    logic [3:0] mode;
    logic [4:0] scan_step;
    logic run_led;
    logic prog_led;
    logic error_led;
    logic alarm_relay;
    logic wd_fault;
    int miscompares = 0;
    int checked = 0;
    int unsigned seed = 81;
    logic [15:0] mem [int];
    logic [11:0] bases [3] = '{12'h005, PRESET_BASE, CURRENT_BASE};
    logic [15:0] got, prog_w, keep_w, aux_w, in_w, lo, hi, fe, fv, f_in;
    int i;

    pmsc_top i_pmsc_top (.clock(clock), .reset_n(reset_n), .mode_switch(mode_switch),
        .init_key(init_key), .diag_error(diag_error), .host_run_cmd(host_run_cmd),
        .host_pause_cmd(host_pause_cmd), .ext_inputs(ext_inputs), .ext_outputs(ext_outputs),
        .periph(periph), .bus(bus), .rdata(rdata), .mode(mode), .scan_step(scan_step),
        .run_led(run_led), .prog_led(prog_led), .error_led(error_led),
        .alarm_relay(alarm_relay), .wd_fault(wd_fault));
    pmsc_partner i_pmsc_partner (.clock(clock), .load(load), .load_value(load_value),
        .run_req(run_req), .pause_req(pause_req), .ext_inputs(ext_inputs),
        .host_run_cmd(host_run_cmd), .host_pause_cmd(host_pause_cmd));

    initial begin
        forever #2.5 clock = ~clock;
    end

    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : xs

    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask : tick

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus.wr <= 1'b0;
        if (a[15:14] != AREA_CTRL) mem[a] = d;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic rchk(input logic [15:0] a);
        rd(a, got);
        chk(got, mem[a]);
    endtask : rchk

    task automatic wait_mode(input logic [3:0] e);
        int k;
        for (k = 0; k < 40 && mode !== e; k++) begin
            @(posedge clock);
            #1;
        end
        chk({12'h000, mode}, {12'h000, e});
        if (k == 40) test_done();
    endtask : wait_mode

    task automatic power_cycle();
        @(posedge clock);
        reset_n <= 1'b0;
        tick(3);
        reset_n <= 1'b1;
        tick(6);
    endtask : power_cycle

    task automatic drive_in(input logic [15:0] v);
        @(posedge clock);
        load <= 1'b1;
        load_value <= v;
        @(posedge clock);
        load <= 1'b0;
        tick(20);
        #1;
    endtask : drive_in

    task automatic host(input logic run);
        @(posedge clock);
        run_req <= run;
        pause_req <= !run;
        @(posedge clock);
        run_req <= 1'b0;
        pause_req <= 1'b0;
    endtask : host

    task automatic press_init();
        @(posedge clock);
        init_key <= 1'b1;
        tick(4);
        init_key <= 1'b0;
    endtask : press_init

    initial begin
        tick(50000);
        miscompares++;
        test_done();
    end

    initial begin
        tick(3);
        reset_n <= 1'b1;
        tick(6);
        wait_mode(MODE_STOP);
        prog_w = xs();
        keep_w = xs();
        aux_w = xs();
        wr({12'hC00, CTRL_PROG}, prog_w);
        wr(16'h0000, aux_w);
        mem[16'h0000] = 16'h0000;
        rchk(16'h0000);
        wr(16'h4000, keep_w);
        rchk(16'h4000);
        mode_switch <= SW_RUN;
        wait_mode(MODE_RUN);
        chk({14'h0000, run_led, prog_led}, 16'h0002);
        wr(16'h0000, aux_w);
        rchk(16'h0000);
        in_w = xs();
        drive_in(in_w);
        chk(ext_outputs, (in_w & prog_w) ^ aux_w ^ keep_w);
        rd({12'hC00, CTRL_INPUTS}, got);
        chk(got, in_w);
        wr({12'hC00, CTRL_PROG}, ~prog_w);
        in_w = xs();
        drive_in(in_w);
        chk(ext_outputs, (in_w & prog_w) ^ aux_w ^ keep_w);
        fe = xs();
        fv = xs();
        wr({12'hC00, CTRL_FORCE_EN}, fe);
        wr({12'hC00, CTRL_FORCE_VAL}, fv);
        tick(20);
        #1;
        f_in = (in_w & ~fe) | (fv & fe);
        chk(ext_outputs, ((((f_in & prog_w) ^ aux_w ^ keep_w)) & ~fe) | (fv & fe));
        rd({12'hC00, CTRL_INPUTS}, got);
        chk(got, f_in);
        wr({12'hC00, CTRL_FORCE_EN}, 16'h0000);
        rd({12'hC00, CTRL_WD_COUNT}, got);
        chk(got, 16'h0000);
        for (i = 0; i < 3; i++) begin
            lo = xs();
            hi = xs();
            wr({4'h8, bases[i]}, lo);
            wr({4'h8, bases[i]} + 16'h0001, hi);
            rchk({4'h8, bases[i]});
            rd({12'hC00, CTRL_DWORD_LO}, got);
            chk(got, lo);
            rd({12'hC00, CTRL_DWORD_HI}, got);
            chk(got, hi);
        end
        periph <= '{valid: 1'b1, addr: 12'h007, data: lo};
        tick(10);
        periph <= '0;
        mem[16'h8007] = lo;
        rchk(16'h8007);
        mode_switch <= SW_PROG;
        wait_mode(MODE_STOP);
        mem[16'h0000] = 16'h0000;
        rchk(16'h0000);
        rchk(16'h8900);
        chk(ext_outputs, 16'h0000);
        power_cycle();
        wait_mode(MODE_STOP);
        rchk(16'h4000);
        rchk(16'h8800);
        rchk(16'h8900);
        wr({12'hC00, CTRL_CLEAR_DATA}, 16'h0001);
        mem[16'h8005] = 16'h0000;
        rchk(16'h8005);
        mode_switch <= SW_REMOTE;
        wait_mode(MODE_PAUSE);
        host(1'b1);
        wait_mode(MODE_RUN);
        wr(16'h0000, aux_w);
        host(1'b0);
        wait_mode(MODE_PAUSE);
        rchk(16'h0000);
        power_cycle();
        wait_mode(MODE_PAUSE);
        host(1'b1);
        wait_mode(MODE_RUN);
        power_cycle();
        wait_mode(MODE_RUN);
        mode_switch <= SW_PROG;
        wait_mode(MODE_STOP);
        host(1'b1);
        tick(10);
        wait_mode(MODE_STOP);
        for (i = 0; i < 2; i++) begin
            mode_switch <= SW_RUN;
            wait_mode(MODE_RUN);
            @(posedge clock);
            diag_error <= 1'b1;
            tick(3);
            diag_error <= 1'b0;
            wait_mode(MODE_ERROR);
            tick(4);
            #1;
            chk(ext_outputs, 16'h0000);
            chk({15'h0000, alarm_relay}, 16'h0001);
            chk({14'h0000, error_led, wd_fault}, 16'h0002);
            press_init();
            wait_mode(MODE_ERROR);
            mode_switch <= SW_PROG;
            tick(6);
            wait_mode(MODE_ERROR);
            if (i == 0) press_init();
            else power_cycle();
            wait_mode(MODE_STOP);
        end
        test_done();
    end
endmodule : pmsc_top_bench

`default_nettype wire
